// ===== pin_partner.sv
// Model of the outside world on the count pin and the direction pin.
`timescale 1ns/1ps
`default_nettype none
module pin_partner
  import timer_pkg::*;
(
  input wire logic core_clk,
  input wire logic count_pin_o,
  input wire logic count_pin_oe,
  output logic count_pin_i,
  output logic direction_pin,
  output int half_period
);
  logic drive_low = 1'b0; // High while the model pulls the count pin low.
  logic dir_r = PIN_IDLE; // Level that the model puts on the direction pin.
  logic last_r = PIN_IDLE; // Pin level seen at the previous edge.
  int run_len = 0; // Cycles since the pin last changed.

  // The pin has a pull-up, so it idles high when nobody drives it low.
  // The square wave wins whenever the block enables its driver.
  assign count_pin_i = count_pin_oe ? count_pin_o : ~drive_low;
  assign direction_pin = dir_r;

  // Measure the length of the latest constant stretch on the pin.
  always @(posedge core_clk) begin
    last_r <= count_pin_i;
    if (count_pin_i != last_r) begin
      half_period <= run_len;
      run_len <= 1;
    end else begin
      run_len <= run_len + 1;
    end
  end

  // Each pulse stays low and high for three cycles so the synchroniser sees it.
  task automatic falls(input int n);
    repeat (n) begin
      drive_low <= 1'b1;
      repeat (3) @(posedge core_clk);
      drive_low <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
  endtask : falls

  // Move the direction pin right after an edge.
  task automatic set_dir(input logic d);
    dir_r <= d;
    @(posedge core_clk);
  endtask : set_dir
endmodule : pin_partner
`default_nettype wire

// ===== pin_sync.sv
// Two-stage synchroniser with a falling-edge detector for one pin.
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import timer_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic pin_i,
  output logic level,
  output logic fall
);
  logic meta_r; // First stage, read only by the second stage.
  logic sync_r; // Second stage, safe to use.
  logic last_r; // Previous safe value for the edge detector.

  // Stages idle high so a released reset shows no false edge.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      meta_r <= PIN_IDLE;
      sync_r <= PIN_IDLE;
      last_r <= PIN_IDLE;
    end else begin
      meta_r <= pin_i;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign level = sync_r;
  // One-cycle pulse per falling edge.
  assign fall = last_r & ~sync_r;
endmodule : pin_sync
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the up/down reload timer with clock output.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import timer_pkg::*;
  logic core_clk = 1'b0; // Bench clock, 40 ns period.
  logic reset = 1'b1; // Synchronous reset, held for eight cycles.
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] readdata;
  logic waitrequest, count_pin_i, count_pin_o, count_pin_oe, direction_pin, irq;
  int fails = 0; // Mismatches seen.
  int n_compared = 0; // Comparisons made.
  int cycles = 0; // Clock cycles since time zero, for the hang guard.
  int half; // Latest half period seen on the count pin.
  logic [31:0] q;
  logic [15:0] rel, cnt, v, e;
  logic wrapped;
  logic other_ovf = 1'b0; // Overflow pulses of the other timer, drawn at random.
  logic rx_tick; // Receive clock tick from the block.
  logic tx_tick; // Transmit clock tick from the block.

  always #20 core_clk = ~core_clk;

  // The other timer pulses at random so the tick pass-through is exercised.
  always @(posedge core_clk) begin
    other_ovf <= 1'($urandom);
  end

  updown_reload_timer_clockout uut (.core_clk(core_clk), .reset(reset), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .count_pin_i(count_pin_i),
    .count_pin_o(count_pin_o), .count_pin_oe(count_pin_oe), .direction_pin(direction_pin),
    .other_timer_overflow(other_ovf), .irq(irq), .rx_clock_tick(rx_tick),
    .tx_clock_tick(tx_tick));

  pin_partner pins (.core_clk(core_clk), .count_pin_o(count_pin_o),
    .count_pin_oe(count_pin_oe), .count_pin_i(count_pin_i),
    .direction_pin(direction_pin), .half_period(half));

  // Expected next count when counting up or down, wraps included.
  function automatic logic [15:0] next_up(input logic [15:0] c, input logic [15:0] r);
    return (c == COUNT_TOP) ? r : c + 16'h0001;
  endfunction : next_up
  function automatic logic [15:0] next_down(input logic [15:0] c, input logic [15:0] r);
    return (c == r) ? COUNT_TOP : c - 16'h0001;
  endfunction : next_down

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    if (fails == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  // One Avalon access; the request holds until waitrequest is sampled low.
  // Only the bench's cycle guard ends a wait that never completes.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    address <= a;
    writedata <= {24'h000000, d};
    write <= wr;
    read <= ~wr;
    do begin
      @(posedge core_clk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge core_clk);
  endtask : bus

  // The 16-bit registers are two byte registers one word apart.
  task automatic set16(input logic [7:0] a, input logic [15:0] d);
    bus(1'b1, a, d[7:0]);
    bus(1'b1, a + 8'h04, d[15:8]);
  endtask : set16
  task automatic get16(input logic [7:0] a, output logic [15:0] d);
    bus(1'b0, a, 8'h00);
    d[7:0] = q[7:0];
    bus(1'b0, a + 8'h04, 8'h00);
    d[15:8] = q[7:0];
  endtask : get16

  // Own wraps show as ticks in step with the pin toggles; else the other pulse, one late.
  task automatic watch_ticks(input logic own, input int n);
    logic prev_ovf;
    logic prev_pin;
    @(posedge core_clk);
    prev_ovf = other_ovf;
    prev_pin = count_pin_o;
    repeat (n) begin
      @(posedge core_clk);
      check("rx_tick", rx_tick, own ? (count_pin_o != prev_pin) : prev_ovf);
      check("tx_tick", tx_tick, own ? (count_pin_o != prev_pin) : prev_ovf);
      prev_ovf = other_ovf;
      prev_pin = count_pin_o;
    end
  endtask : watch_ticks

  // Guard against a hang; the whole run needs about 1300 cycles.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      print_verdict();
    end
  end

  initial begin
    v = 16'($urandom(32'hBF2A));
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    // Reset values, plus one unmapped word that must read as zero.
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, 8'hC8 + 8'(4 * i), 8'h00);
      check("reg_reset", q, 32'h00000000);
    end
    check("pin_oe_reset", count_pin_oe, 1'b0);
    // A write without lane 0 is accepted but leaves the register alone.
    byteenable <= {3'($urandom), 1'b0};
    bus(1'b1, RELL_ADDR, 8'h5A);
    byteenable <= 4'hF;
    bus(1'b0, RELL_ADDR, 8'h00);
    check("lane_ignored", q, 32'h00000000);
    // Control bits read back in place; run stays off so nothing moves.
    v = 16'($urandom) & 16'h003B;
    bus(1'b1, CTRL_ADDR, v[7:0]);
    bus(1'b0, CTRL_ADDR, 8'h00);
    check("ctrl_rw", q, {24'h000000, v[7:0]});
    bus(1'b1, CTRL_ADDR, 8'h00);
    // Stopped count holds; running timer steps once per six cycles.
    set16(CNTL_ADDR, 16'h1234);
    repeat (30) @(posedge core_clk);
    get16(CNTL_ADDR, v);
    check("count_hold", v, 16'h1234);
    bus(1'b1, CTRL_ADDR, 8'h04);
    repeat (60) @(posedge core_clk);
    bus(1'b1, CTRL_ADDR, 8'h00);
    get16(CNTL_ADDR, v);
    e = v - 16'h1234;
    check("timer_div", (e >= 16'h000A && e <= 16'h000B), 1'b1);
    // Counting pin edges near the top, so the wrap loads the reload pair.
    for (int k = 0; k < 3; k++) begin
      cnt = 16'hFFFB + 16'($urandom % 4);
      rel = 16'($urandom);
      set16(RELL_ADDR, rel);
      set16(CNTL_ADDR, cnt);
      bus(1'b1, CTRL_ADDR, 8'h06);
      pins.falls(6);
      repeat (4) @(posedge core_clk);
      e = cnt;
      wrapped = 1'b0;
      for (int j = 0; j < 6; j++) begin
        wrapped |= (e == COUNT_TOP);
        e = next_up(e, rel);
      end
      get16(CNTL_ADDR, v);
      check("count_up", v, e);
      bus(1'b0, CTRL_ADDR, 8'h00);
      check("ctrl_up", q, {24'h000000, wrapped, 7'h06});
      check("irq_up", irq, wrapped);
      bus(1'b1, CTRL_ADDR, 8'h00);
    end
    // Down through the reload value, then up through the top again.
    rel = 16'($urandom % 16'hFFF0);
    bus(1'b1, MODE_ADDR, 8'h01);
    pins.set_dir(1'b0);
    set16(RELL_ADDR, rel);
    set16(CNTL_ADDR, rel + 16'h0001);
    bus(1'b1, CTRL_ADDR, 8'h06);
    pins.falls(2);
    repeat (4) @(posedge core_clk);
    get16(CNTL_ADDR, v);
    check("count_down", v, next_down(next_down(rel + 16'h0001, rel), rel));
    bus(1'b0, CTRL_ADDR, 8'h00);
    check("ctrl_down", q, 32'h000000C6);
    check("irq_down", irq, 1'b1);
    bus(1'b1, CTRL_ADDR, 8'h06);
    pins.set_dir(1'b1);
    pins.falls(1);
    repeat (4) @(posedge core_clk);
    get16(CNTL_ADDR, v);
    check("count_updn", v, next_up(COUNT_TOP, rel));
    bus(1'b0, CTRL_ADDR, 8'h00);
    check("ctrl_updn", q, 32'h000000C6);
    bus(1'b1, CTRL_ADDR, 8'h00);
    bus(1'b1, MODE_ADDR, 8'h00);
    // Direction pin fall: reload into the count, then capture of the count.
    for (int k = 0; k < 2; k++) begin
      cnt = 16'($urandom);
      rel = 16'($urandom);
      set16(RELL_ADDR, rel);
      set16(CNTL_ADDR, cnt);
      bus(1'b1, CTRL_ADDR, 8'h08 | 8'(k));
      pins.set_dir(1'b0);
      repeat (5) @(posedge core_clk);
      get16((k == 0) ? CNTL_ADDR : RELL_ADDR, v);
      check("ext_event", v, (k == 0) ? rel : cnt);
      bus(1'b0, CTRL_ADDR, 8'h00);
      check("ext_flag", q, {24'h000000, 8'h48 | 8'(k)});
      check("irq_ext", irq, 1'b1);
      pins.set_dir(1'b1);
      bus(1'b1, CTRL_ADDR, 8'h00);
    end
    // Clock-out set up in the required order; no interrupt on its wraps.
    rel = 16'hFFF0 - 16'($urandom % 8);
    bus(1'b1, MODE_ADDR, 8'h02);
    bus(1'b1, CTRL_ADDR, 8'h00);
    set16(RELL_ADDR, rel);
    set16(CNTL_ADDR, rel);
    bus(1'b1, CTRL_ADDR, 8'h04);
    repeat (300) @(posedge core_clk);
    check("clk_out_oe", count_pin_oe, 1'b1);
    check("clk_out_half", half, 2 * (65536 - int'(rel)));
    check("irq_clk_out", irq, 1'b0);
    watch_ticks(1'b0, 40);
    // Serial clock selects share the reload and keep the overflow flag clear.
    bus(1'b1, CTRL_ADDR, 8'h34);
    repeat (300) @(posedge core_clk);
    bus(1'b0, CTRL_ADDR, 8'h00);
    check("ctrl_baud", q, 32'h00000034);
    check("clk_out_baud", half, 2 * (65536 - int'(rel)));
    watch_ticks(1'b1, 120);
    print_verdict();
  end
endmodule : tb
`default_nettype wire

// ===== tick_gen.sv
// Divider that makes the slow timer tick and the fast clock-out tick.
`timescale 1ns/1ps
`default_nettype none
module tick_gen
  import timer_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  output logic tick_timer,
  output logic tick_fast
);
  // Next value of a wrapping divide counter.
  function automatic logic [2:0] div_next(input logic [2:0] cnt, input logic [2:0] div);
    div_next = (cnt == div - 3'h1) ? 3'h0 : cnt + 3'h1;
  endfunction : div_next

  logic [2:0] slow_r; // Position inside the divide-by-six period.
  logic [2:0] fast_r; // Position inside the divide-by-two period.
  logic slow_wrap;
  logic fast_wrap;

  assign slow_wrap = (slow_r == TIMER_DIV - 3'h1);
  assign fast_wrap = (fast_r == FAST_DIV - 3'h1);

  // Both counters run free so the ticks keep a fixed phase.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      slow_r <= 3'h0;
      fast_r <= 3'h0;
      tick_timer <= 1'b0;
      tick_fast <= 1'b0;
    end else begin
      slow_r <= div_next(slow_r, TIMER_DIV);
      fast_r <= div_next(fast_r, FAST_DIV);
      tick_timer <= slow_wrap;
      tick_fast <= fast_wrap;
    end
  end
endmodule : tick_gen
`default_nettype wire

// ===== timer_pkg.sv
// Shared constants and types for the up/down reload timer.
`default_nettype none
package timer_pkg;
  // Byte addresses of the registers, one aligned word each.
  localparam logic [7:0] CTRL_ADDR = 8'hC8;
  localparam logic [7:0] MODE_ADDR = 8'hCC;
  localparam logic [7:0] CNTL_ADDR = 8'hD0;
  localparam logic [7:0] CNTH_ADDR = 8'hD4;
  localparam logic [7:0] RELL_ADDR = 8'hD8;
  localparam logic [7:0] RELH_ADDR = 8'hDC;
  // Bit positions inside the mode register.
  localparam int MODE_DOWN_COUNT_ENABLE_BIT = 0;
  localparam int MODE_OE_BIT = 1;
  // Reset values.
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic PIN_IDLE = 1'b1;
  // Top of the 16-bit count, used for wrap and for the down reload.
  localparam logic [15:0] COUNT_TOP = 16'hFFFF;
  // Clock dividers: timer clock divided by six, fast clock by two.
  localparam logic [2:0] TIMER_DIV = 3'h6;
  localparam logic [2:0] FAST_DIV = 3'h2;
  // Control register layout, bit 7 first.
  typedef struct packed {
    logic overflow_flag;
    logic external_flag;
    logic receive_clock_select;
    logic transmit_clock_select;
    logic external_enable;
    logic run_control;
    logic counter_timer_select;
    logic capture_reload_select;
  } ctl_t;
endpackage : timer_pkg
`default_nettype wire

// ===== updown_reload_timer_clockout.sv
// Top of the 16-bit up/down reload timer with clock output.
`timescale 1ns/1ps
`default_nettype none
module updown_reload_timer_clockout
  import timer_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic count_pin_i,
  output logic count_pin_o,
  output logic count_pin_oe,
  input wire logic direction_pin,
  input wire logic other_timer_overflow,
  output logic irq,
  output logic rx_clock_tick,
  output logic tx_clock_tick
);
  // One step of a count byte: {carry or borrow, new byte}.
  function automatic logic [8:0] byte_step(input logic [7:0] b, input logic up,
                                           input logic en);
    if (!en) begin
      byte_step = {1'b0, b};
    end else if (up) begin
      byte_step = {1'b0, b} + 9'h001;
    end else begin
      byte_step = {(b == 8'h00), b - 8'h01};
    end
  endfunction : byte_step

  // Registers seen by software.
  ctl_t control_r; // Control register.
  ctl_t control_nxt; // Next control value.
  logic down_count_enable_r; // Direction pin steers the count.
  logic clock_out_enable_r; // Square wave drives the count pin.
  logic [7:0] count_low_byte_r; // Low count byte.
  logic [7:0] count_high_byte_r; // High count byte.
  logic [7:0] reload_low_r; // Low reload or capture byte.
  logic [7:0] reload_high_r; // High reload or capture byte.

  // Bus side state.
  logic waitrequest_r; // Stall until the access is accepted.
  logic [31:0] readdata_r; // Read data for the accepted access.
  logic pin_o_r; // Square wave level.
  logic irq_r; // Interrupt request level.
  logic rx_tick_r; // Receive clock tick.
  logic tx_tick_r; // Transmit clock tick.

  // Ticks and pin events.
  logic tick_timer; // Timer clock divided by six.
  logic tick_fast; // Timer clock divided by two.
  logic cnt_level; // Synchronised count pin, read only by the edge check.
  logic cnt_fall; // Falling edge on the count pin.
  logic dir_level; // Synchronised direction pin.
  logic dir_fall; // Falling edge on the direction pin.

  // Dividers for the timer and the fast clock.
  tick_gen u_tick (
    .core_clk(core_clk),
    .reset(reset),
    .tick_timer(tick_timer),
    .tick_fast(tick_fast)
  );

  // Count pin input, synchronised before edge detection.
  pin_sync u_cnt_sync (
    .core_clk(core_clk),
    .reset(reset),
    .pin_i(count_pin_i),
    .level(cnt_level),
    .fall(cnt_fall)
  );

  // Direction pin, used as a level and as an edge source.
  pin_sync u_dir_sync (
    .core_clk(core_clk),
    .reset(reset),
    .pin_i(direction_pin),
    .level(dir_level),
    .fall(dir_fall)
  );

  // Bus decode: an access completes on the cycle waitrequest is low.
  logic req;
  logic acc;
  logic wr_acc;
  logic [7:0] wd;
  logic sel_ctrl;
  logic sel_mode;
  logic sel_cntl;
  logic sel_cnth;
  logic sel_rell;
  logic sel_relh;
  logic wr_ctrl;
  logic wr_mode;
  logic wr_cntl;
  logic wr_cnth;
  logic wr_rell;
  logic wr_relh;
  logic cnt_wr;
  logic [7:0] rd_byte;

  assign req = read | write;
  assign acc = req & ~waitrequest_r;
  // Only lane 0 carries data; other lanes are ignored.
  assign wr_acc = acc & write & byteenable[0];
  assign wd = writedata[7:0];
  assign sel_ctrl = (address == CTRL_ADDR);
  assign sel_mode = (address == MODE_ADDR);
  assign sel_cntl = (address == CNTL_ADDR);
  assign sel_cnth = (address == CNTH_ADDR);
  assign sel_rell = (address == RELL_ADDR);
  assign sel_relh = (address == RELH_ADDR);
  assign wr_ctrl = wr_acc & sel_ctrl;
  assign wr_mode = wr_acc & sel_mode;
  assign wr_cntl = wr_acc & sel_cntl;
  assign wr_cnth = wr_acc & sel_cnth;
  assign wr_rell = wr_acc & sel_rell;
  assign wr_relh = wr_acc & sel_relh;
  assign cnt_wr = wr_cntl | wr_cnth;

  // Read mux; unmapped addresses read as zero.
  assign rd_byte = sel_ctrl ? control_r :
                   sel_mode ? {6'h00, clock_out_enable_r, down_count_enable_r} :
                   sel_cntl ? count_low_byte_r :
                   sel_cnth ? count_high_byte_r :
                   sel_rell ? reload_low_r :
                   sel_relh ? reload_high_r : 8'h00;

  // Count source and direction.
  logic baud_mode;
  logic fast_src;
  logic src_tick;
  logic step;
  logic count_up;
  logic [15:0] cnt;
  logic [15:0] rel;
  logic at_top;
  logic at_rel;
  logic wrap_up;
  logic wrap_down;
  logic wrap;
  logic [8:0] low_step;
  logic [8:0] high_step;
  logic [15:0] stepped;
  logic ext_evt;
  logic ext_reload;
  logic ext_capture;
  logic [15:0] cnt_auto;
  logic [15:0] cnt_nxt;
  logic [15:0] rel_nxt;

  assign baud_mode = control_r.receive_clock_select | control_r.transmit_clock_select;
  // Clock-out and baud generation both run from the fast tick.
  assign fast_src = clock_out_enable_r | baud_mode;
  assign src_tick = fast_src ? tick_fast :
                    control_r.counter_timer_select ? cnt_fall : tick_timer;
  assign step = control_r.run_control & src_tick;
  // Without down-count enable the count always goes up.
  assign count_up = ~down_count_enable_r | dir_level;
  assign cnt = {count_high_byte_r, count_low_byte_r};
  assign rel = {reload_high_r, reload_low_r};
  assign at_top = (cnt == COUNT_TOP);
  assign at_rel = (cnt == rel);
  assign wrap_up = step & count_up & at_top;
  assign wrap_down = step & ~count_up & at_rel;
  assign wrap = wrap_up | wrap_down;
  // The low byte carry or borrow feeds the high byte.
  assign low_step = byte_step(count_low_byte_r, count_up, step);
  assign high_step = byte_step(count_high_byte_r, count_up, low_step[8]);
  assign stepped = {high_step[7:0], low_step[7:0]};
  // In up/down mode the direction pin is a level, not an event source.
  assign ext_evt = control_r.external_enable & dir_fall & ~down_count_enable_r;
  assign ext_reload = ext_evt & ~control_r.capture_reload_select;
  assign ext_capture = ext_evt & control_r.capture_reload_select;
  // External reload beats a wrap; a wrap beats a plain step.
  assign cnt_auto = ext_reload ? rel :
                    wrap_up ? rel :
                    wrap_down ? COUNT_TOP :
                    stepped;
  // Software writes to a count byte win over the hardware.
  assign cnt_nxt = {wr_cnth ? wd : cnt_auto[15:8], wr_cntl ? wd : cnt_auto[7:0]};
  assign rel_nxt = {wr_relh ? wd : (ext_capture ? cnt[15:8] : reload_high_r),
                    wr_rell ? wd : (ext_capture ? cnt[7:0] : reload_low_r)};

  // Control flags; a hardware set wins over a software clear.
  logic tf_set;
  logic exf_toggle;
  ctl_t ctl_sw;
  assign tf_set = wrap & ~baud_mode;
  assign exf_toggle = wrap & down_count_enable_r;
  assign ctl_sw = wr_ctrl ? ctl_t'(wd) : control_r;

  // Merge the software view with the hardware events.
  always_comb begin
    control_nxt = ctl_sw;
    control_nxt.overflow_flag = ctl_sw.overflow_flag | tf_set;
    if (ext_evt) begin
      control_nxt.external_flag = 1'b1;
    end else if (exf_toggle) begin
      control_nxt.external_flag = ~ctl_sw.external_flag;
    end
  end

  // Side outputs computed from the current state.
  logic irq_nxt;
  logic pin_o_nxt;
  logic rx_tick_nxt;
  logic tx_tick_nxt;
  // Clock-out overflows and up/down flag toggles request nothing.
  assign irq_nxt = (control_r.overflow_flag & ~clock_out_enable_r) |
                   (control_r.external_flag & ~down_count_enable_r);
  // One toggle per wrap gives a period of two wrap distances.
  assign pin_o_nxt = (clock_out_enable_r & wrap) ? ~pin_o_r : pin_o_r;
  assign rx_tick_nxt = control_r.receive_clock_select ? wrap : other_timer_overflow;
  assign tx_tick_nxt = control_r.transmit_clock_select ? wrap : other_timer_overflow;

  // Bus handshake: one stall cycle, then one cycle with waitrequest low.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      waitrequest_r <= 1'b1;
      readdata_r <= 32'h0000_0000;
    end else begin
      waitrequest_r <= ~(req & waitrequest_r);
      if (read & waitrequest_r) begin
        readdata_r <= {24'h000000, rd_byte};
      end
    end
  end

  // Control, mode and flags.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      control_r <= ctl_t'(CTRL_RESET);
      down_count_enable_r <= 1'b0;
      clock_out_enable_r <= 1'b0;
    end else begin
      control_r <= control_nxt;
      if (wr_mode) begin
        down_count_enable_r <= wd[MODE_DOWN_COUNT_ENABLE_BIT];
        clock_out_enable_r <= wd[MODE_OE_BIT];
      end
    end
  end

  // Count and reload bytes.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      count_low_byte_r <= BYTE_RESET;
      count_high_byte_r <= BYTE_RESET;
      reload_low_r <= BYTE_RESET;
      reload_high_r <= BYTE_RESET;
    end else begin
      {count_high_byte_r, count_low_byte_r} <= cnt_nxt;
      {reload_high_r, reload_low_r} <= rel_nxt;
    end
  end

  // Registered side outputs.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pin_o_r <= PIN_IDLE;
      irq_r <= 1'b0;
      rx_tick_r <= 1'b0;
      tx_tick_r <= 1'b0;
    end else begin
      pin_o_r <= pin_o_nxt;
      irq_r <= irq_nxt;
      rx_tick_r <= rx_tick_nxt;
      tx_tick_r <= tx_tick_nxt;
    end
  end

  assign readdata = readdata_r;
  assign waitrequest = waitrequest_r;
  assign count_pin_o = pin_o_r;
  assign count_pin_oe = clock_out_enable_r;
  assign irq = irq_r;
  assign rx_clock_tick = rx_tick_r;
  assign tx_clock_tick = tx_tick_r;

  // Checks on the counting behaviour.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  // A stopped counter holds its value unless software writes it or an external reload loads it.
  hold_count_a: assert property (!control_r.run_control && !cnt_wr && !ext_reload
    |=> $stable(cnt)) else $error("count moved while stopped");
  // A plain up step adds one across both bytes.
  up_step_a: assert property (step && count_up && !at_top && !cnt_wr && !ext_reload
    |=> cnt == $past(cnt) + 16'h0001) else $error("bad up step");
  // Up wrap loads the reload pair.
  up_wrap_a: assert property (wrap_up && !cnt_wr && !ext_reload
    |=> cnt == $past(rel)) else $error("no reload on up wrap");
  // Down wrap loads the top value.
  down_wrap_a: assert property (wrap_down && !cnt_wr && !ext_reload
    |=> cnt == 16'hFFFF) else $error("no top load on down wrap");
  // Overflow flag is set outside baud mode.
  flag_set_a: assert property (wrap && !baud_mode
    |=> control_r.overflow_flag) else $error("overflow flag not set");
  // Overflow flag is untouched by a wrap in baud mode.
  flag_baud_a: assert property (wrap && baud_mode && !wr_ctrl
    |=> control_r.overflow_flag == $past(control_r.overflow_flag))
    else $error("flag set in baud mode");
  // External flag toggles on each wrap in up/down mode.
  exf_toggle_a: assert property (wrap && down_count_enable_r && !wr_ctrl
    |=> control_r.external_flag != $past(control_r.external_flag))
    else $error("external flag did not toggle");
  // Clock-out toggles the pin on each wrap.
  pin_toggle_a: assert property (wrap && clock_out_enable_r
    |=> count_pin_o != $past(count_pin_o)) else $error("pin did not toggle");
  // Clock-out overflows raise no interrupt.
  co_noirq_a: assert property (clock_out_enable_r && !down_count_enable_r
    && !control_r.external_flag |=> !irq) else $error("irq in clock-out mode");
  // Timer steps are six cycles apart.
  timer_div_a: assert property (step && !fast_src && !control_r.counter_timer_select
    |=> !step [*5]) else $error("timer step too soon");
  // A pin edge is counted in one cycle only.
  pin_once_a: assert property (step && !fast_src && control_r.counter_timer_select
    |=> !step) else $error("edge counted twice");
  // An edge pulse comes only with the pin newly low, so a glitch-free level gives one count.
  pin_fall_a: assert property (cnt_fall |-> !cnt_level && $past(cnt_level))
    else $error("false pin edge");

  up_wrap_c: cover property (wrap_up);
  down_wrap_c: cover property (wrap_down);
  pin_toggle_c: cover property (wrap && clock_out_enable_r);
  ext_evt_c: cover property (ext_evt);
endmodule : updown_reload_timer_clockout
`default_nettype wire
